// ===== hw/sabi_core.sv
// Control and bus-interface logic of a 12-bit successive-approximation converter.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// (RULE1) Result lines are driven only while chip select and read are both low.
// (RULE2) Result is a parallel 12-bit word, bit 11 is the most significant.
// (RULE3) Both strobes low together start a conversion.
// (RULE4) Busy is low for the whole conversion and high otherwise.
// (RULE5) Clock output is the inverse of the conversion clock input.
// (RULE6) Read fall under 25 ns before a clock fall skips that fall.
// (RULE7) Host keeps the read fall outside 25 to 100 ns before a clock fall.
// (RULE8) Start strobes are ignored while a conversion is running.
// (RULE9) Register presets to half scale; top bit decided at second clock fall.
// (RULE10) At the end busy rises and the result moves to the output latch.
// (RULE11) Each read while idle returns the previous result and starts a new conversion.
// (RULE12) After reset busy is high, outputs float and the latch reads zero.
module sabi_core (
   // Clock, reset and enable.
   input  wire logic                 sys_clk,
   input  wire logic                 rst_b,
   input  wire logic                 clk_en,
   // Host strobes.
   input  wire sabi_pkg::sabi_strobe_t strobe,
   // Conversion clock and comparator.
   input  wire logic                 conv_clock_in,
   input  wire logic                 comp_in,
   output logic                      inverted_clock_out,
   // Result bus and status.
   output sabi_pkg::sabi_bus_out_t   result_bus,
   output logic                      busy_b
);

   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV} sabi_state_t;

   // ****************************************************************
   // Conversion clock edge detection.
   // ****************************************************************
   logic clk_fall;

   sabi_edge_det u_edge (
      .sys_clk    (sys_clk),
      .rst_b      (rst_b),
      .clk_en     (clk_en),
      .level_in   (conv_clock_in),
      .fall_pulse (clk_fall),
      .rise_pulse ()
   );

   // ****************************************************************
   // Control state.
   // ****************************************************************
   sabi_state_t  state_r, state_nxt;
   logic [11:0]  appr_r, appr_nxt;        // approximation_register
   logic [11:0]  latch_r, latch_nxt;
   logic [3:0]   bit_r, bit_nxt;
   logic [1:0]   falls_r, falls_nxt;
   logic [7:0]   gap_r, gap_nxt;
   logic         sel_r, sel_nxt;
   logic         busy_b_r, busy_b_nxt;
   logic         inv_r, inv_nxt;
   sabi_pkg::sabi_bus_out_t bus_r, bus_nxt;

   logic sel_now;
   assign sel_now = ~strobe.cs_b & ~strobe.rd_b;

   // Next-state logic of the conversion sequencer.
   always_comb begin
      state_nxt  = state_r;
      appr_nxt   = appr_r;
      latch_nxt  = latch_r;
      bit_nxt    = bit_r;
      falls_nxt  = falls_r;
      gap_nxt    = gap_r;
      busy_b_nxt = busy_b_r;
      sel_nxt    = sel_now;
      case (state_r)
         ST_IDLE: begin
            // A new select edge starts a conversion.
            if (sel_now && !sel_r) begin                        // [RULE3] [RULE11]
               appr_nxt   = sabi_pkg::HALF_SCALE;               // [RULE9]
               busy_b_nxt = 1'b0;                               // [RULE4]
               falls_nxt  = 2'd0;
               gap_nxt    = 8'h00;
               bit_nxt    = sabi_pkg::TOP_BIT;
               state_nxt  = ST_WAIT;
            end
         end
         ST_WAIT: begin
            // Counts time since the start to classify the first clock fall.
            if (gap_r != sabi_pkg::GAP_SAT) begin
               gap_nxt = gap_r + 8'h01;
            end
            if (clk_fall) begin
               // A fall too close to the start is not counted.
               if (gap_r >= 8'(sabi_pkg::ALIGN_MIN_CYC) || falls_r != 2'd0) begin // [RULE6]
                  falls_nxt = falls_r + 2'd1;
                  if (falls_r == 2'd1) begin
                     // Second counted fall latches the top bit.
                     if (!comp_in) begin                        // [RULE9]
                        appr_nxt[bit_r] = 1'b0;
                     end
                     if (bit_r != 4'h0) begin
                        appr_nxt[bit_r - 4'h1] = 1'b1;
                     end
                     bit_nxt   = bit_r - 4'h1;
                     state_nxt = ST_CONV;
                  end
               end
            end
         end
         ST_CONV: begin
            // One bit decision per clock fall down to bit zero.
            if (clk_fall) begin
               if (!comp_in) begin                              // [RULE9]
                  appr_nxt[bit_r] = 1'b0;
               end
               if (bit_r == 4'h0) begin
                  latch_nxt  = comp_in ? appr_r : (appr_r & 12'hffe); // [RULE10]
                  busy_b_nxt = 1'b1;                            // [RULE4] [RULE10]
                  state_nxt  = ST_IDLE;
               end else begin
                  appr_nxt[bit_r - 4'h1] = 1'b1;
                  bit_nxt = bit_r - 4'h1;
               end
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      // Strobes during ST_WAIT or ST_CONV do not start or alter a conversion.  [RULE8]
   end

   // Output drivers and clock inversion.
   always_comb begin
      inv_nxt       = ~conv_clock_in;                          // [RULE5]
      bus_nxt.data  = (state_nxt == ST_IDLE && state_r == ST_CONV) ? latch_nxt : latch_r; // [RULE2]
      bus_nxt.oe    = sel_now ? 12'hfff : 12'h000;             // [RULE1]
   end

   // Registers all state.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r  <= ST_IDLE;
         appr_r   <= sabi_pkg::HALF_SCALE;
         latch_r  <= sabi_pkg::RESULT_RST;                     // [RULE12]
         bit_r    <= sabi_pkg::TOP_BIT;
         falls_r  <= 2'd0;
         gap_r    <= 8'h00;
         sel_r    <= 1'b0;
         busy_b_r <= 1'b1;                                     // [RULE12]
         inv_r    <= 1'b1;
         bus_r    <= '0;                                       // [RULE12]
      end else if (clk_en) begin
         state_r  <= state_nxt;
         appr_r   <= appr_nxt;
         latch_r  <= latch_nxt;
         bit_r    <= bit_nxt;
         falls_r  <= falls_nxt;
         gap_r    <= gap_nxt;
         sel_r    <= sel_nxt;
         busy_b_r <= busy_b_nxt;
         inv_r    <= inv_nxt;
         bus_r    <= bus_nxt;
      end
   end

   assign busy_b             = busy_b_r;
   assign result_bus         = bus_r;
   assign inverted_clock_out = inv_r;

   // ****************************************************************
   // Checks.
   // ****************************************************************
   AST_OE_FOLLOWS_SEL: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE1]
      clk_en |=> (result_bus.oe == ($past(sel_now) ? 12'hfff : 12'h000)))
      else $error("Result drivers do not follow the select strobes.");

   AST_START_BUSY: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE3]
      (clk_en && state_r == ST_IDLE && sel_now && !sel_r) |=> !busy_b)
      else $error("Busy did not fall at conversion start.");

   AST_BUSY_STATE: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE4]
      busy_b == (state_r == ST_IDLE))
      else $error("Busy disagrees with conversion state.");

   AST_CLK_INV: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE5]
      clk_en |=> (inverted_clock_out == !$past(conv_clock_in)))
      else $error("Clock output is not the inverse of the clock input.");

   AST_EARLY_FALL_SKIP: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE6]
      (clk_en && state_r == ST_WAIT && clk_fall && falls_r == 2'd0
       && gap_r < 8'(sabi_pkg::ALIGN_MIN_CYC)) |=> (falls_r == 2'd0))
      else $error("A clock fall too close to the start was counted.");

   AST_NO_RESTART: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE8]
      (state_r == ST_CONV && !clk_fall) |=> (state_r == ST_CONV && $stable(bit_r)))
      else $error("A running conversion changed without a clock fall.");

   AST_HALF_SCALE: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE9]
      (clk_en && state_r == ST_IDLE && sel_now && !sel_r) |=> (appr_r == sabi_pkg::HALF_SCALE))
      else $error("Approximation register not preset to half scale.");

   AST_END_LATCH: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE10]
      (clk_en && state_r == ST_CONV && clk_fall && bit_r == 4'h0)
      |=> (busy_b && state_r == ST_IDLE) ##1 (!clk_en || result_bus.data == latch_r))
      else $error("End of conversion did not raise busy and latch the result.");

   AST_RESULT_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE11]
      (state_r != ST_IDLE) |=> $stable(latch_r) || $past(clk_fall))
      else $error("Output latch changed before conversion end.");

   AST_LATE_FALL_COUNT: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE6]
      (clk_en && state_r == ST_WAIT && clk_fall && falls_r == 2'd0
       && gap_r > 8'(sabi_pkg::ALIGN_MAX_CYC)) |=> (falls_r == 2'd1))
      else $error("A clock fall well after the start was not counted.");

   AST_DATA_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE10]
      (clk_en && !(state_r == ST_CONV && clk_fall && bit_r == 4'h0))
      |=> $stable(result_bus.data))
      else $error("Result data changed away from a conversion end.");

endmodule
`default_nettype wire

// ===== hw/sabi_pkg.sv
// Package of constants and carrier types for the converter bus interface.
package sabi_pkg;

   // ****************************************************************
   // Widths and reset values.
   // ****************************************************************
   localparam int          RES_W      = 12;
   localparam logic [11:0] RESULT_RST = 12'h000;
   localparam logic [11:0] HALF_SCALE = 12'h800;
   localparam logic [3:0]  TOP_BIT    = 4'hb;

   // ****************************************************************
   // Start-to-clock alignment window, times in ns at a 5 ns system clock.
   // ****************************************************************
   localparam int SYS_PERIOD_PS  = 5000;
   localparam int ALIGN_MIN_NS   = 25;
   localparam int ALIGN_MAX_NS   = 100;
   // Least time rounds up; longest time rounds down.
   localparam int ALIGN_MIN_CYC  = (ALIGN_MIN_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
   localparam int ALIGN_MAX_CYC  = (ALIGN_MAX_NS * 1000) / SYS_PERIOD_PS;
   localparam logic [7:0] GAP_SAT = 8'hff;

   // ****************************************************************
   // Carrier types.
   // ****************************************************************
   typedef struct packed {
      logic cs_b;
      logic rd_b;
   } sabi_strobe_t;

   typedef struct packed {
      logic [11:0] data;
      logic [11:0] oe;
   } sabi_bus_out_t;

endpackage

// ===== hw/sabi_edge_det.sv
// Falling-edge detector for the conversion clock input.
`timescale 1ns/1ps
`default_nettype none

module sabi_edge_det (
   // Clock and reset.
   input  wire logic sys_clk,
   input  wire logic rst_b,
   input  wire logic clk_en,
   // Sampled level and edge pulses.
   input  wire logic level_in,
   output logic      fall_pulse,
   output logic      rise_pulse
);

   logic prev_r;
   logic prev_nxt;

   // Next value of the previous-level store.
   always_comb begin
      prev_nxt = level_in;
   end

   // Registers the previous level; starts high so reset makes no rising edge.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         prev_r <= 1'b1;
      end else if (clk_en) begin
         prev_r <= prev_nxt;
      end
   end

   // Edges are combinational compares of the stored and current level.
   assign fall_pulse = clk_en & prev_r & ~level_in;
   assign rise_pulse = clk_en & ~prev_r & level_in;

endmodule
`default_nettype wire

// ===== test/sabi_host_model.sv
// Host bus, conversion clock and comparator model facing the converter.
`timescale 1ns/1ps
`default_nettype none

module sabi_host_model (
   // Clock and converter status.
   input  wire logic              sys_clk,
   input  wire logic              busy_b,
   // Strobes, conversion clock and comparator answer.
   output sabi_pkg::sabi_strobe_t strobe,
   output logic                   conv_clock_in,
   output logic                   comp_in
);
   int          ph      = 0;
   int          since   = 0;
   int          nf      = 0;
   int          low     = 0;
   int          req_ph  = -1;
   int          req_len = 0;
   logic [11:0] pat     = 12'h000;

   initial begin
      strobe = 2'b11;
      conv_clock_in = 1'b1;
      comp_in = 1'b0;
   end

   // Queues one read that falls at the given clock phase and stays low for len cycles.
   task read(input int at_ph, input int len, input logic [11:0] p);
      pat = p;
      req_len = len;
      req_ph = at_ph;
   endtask

   // Phase of the free-running conversion clock, 40 system cycles a period.
   always @(posedge sys_clk) ph <= (ph + 1) % 40;

   // Clock level, read strobes and the comparator answer for each trial bit.
   always @(negedge sys_clk) begin
      since <= since + 1;
      conv_clock_in <= (ph < 20);
      // The converter skips a clock fall that lies under five system cycles after the strobe.
      if (ph == 20 && since >= sabi_pkg::ALIGN_MIN_CYC) nf <= nf + 1;
      if (ph == 0 && nf >= 1 && nf <= 12) comp_in <= pat[12 - nf];
      else if (ph == 0) comp_in <= ~comp_in;
      if (req_ph == ph) begin
         strobe <= 2'b00;
         low <= req_len;
         req_ph <= -1;
         if (busy_b) begin
            since <= 0;
            nf <= 0;
         end
      end else if (low > 1) low <= low - 1;
      else strobe <= 2'b11;
   end
endmodule
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench of the converter bus interface.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
   $display("CHECK FAILED at %0t: got %h, expected %h", $time, (a), (e)); end end

module tb;
   logic                    sys_clk = 1'b0;
   logic                    rst_b = 1'b0;
   logic                    clk_en = 1'b1;
   logic                    conv_clock_in, comp_in, inverted_clock_out, busy_b;
   sabi_pkg::sabi_strobe_t  strobe;
   sabi_pkg::sabi_bus_out_t result_bus;
   int                      failures = 0;
   int                      check_count = 0;
   int                      seed = 84048;
   int                      cycles = 0;
   int                      t0, d_al, d_sk, d_re;
   logic [11:0]             exp_q[$];
   logic [11:0]             latch = 12'h000;
   logic                    busy_q = 1'b1;

   sabi_core i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .strobe(strobe),
      .conv_clock_in(conv_clock_in), .comp_in(comp_in),
      .inverted_clock_out(inverted_clock_out), .result_bus(result_bus), .busy_b(busy_b));
   sabi_host_model i_host (.sys_clk(sys_clk), .busy_b(busy_b), .strobe(strobe),
      .conv_clock_in(conv_clock_in), .comp_in(comp_in));

   // System clock of 5 ns.
   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end

   // Prints the verdict and ends the run.
   task automatic test_done();
      if (failures == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Moves to just after the next rising edge, where outputs have settled.
   task automatic step();
      @(posedge sys_clk);
      #1;
   endtask

   // Waits a bounded time for busy to reach a level.
   task automatic wait_busy(input logic lvl, input int lim);
      int n;
      n = 0;
      while (busy_b !== lvl && n < lim) begin
         step();
         n++;
      end
      `CHK(busy_b, lvl)
   endtask

   // One conversion; extra fires a second read while the first is still running.
   task automatic conv(input int at_ph, input int len, input logic [11:0] p, input bit extra,
                       output int dur);
      int n;
      exp_q.push_back(p);
      i_host.read(at_ph, len, p);
      n = 0;
      while (strobe !== 2'b00 && n < 50) begin
         step();
         n++;
      end
      wait_busy(1'b0, 2);
      t0 = cycles;
      if (extra) begin
         repeat (100) step();
         i_host.read(10, 3, p);
      end
      wait_busy(1'b1, 1200);
      dur = cycles - t0;
      repeat (len + 60) step();
      `CHK(busy_b, 1'b1)
   endtask

   // Reference model of the output latch and drivers, compared every cycle.
   always begin
      step();
      if (rst_b) begin
         if (busy_q === 1'b0 && busy_b === 1'b1) latch = exp_q.pop_front();
         `CHK(result_bus.data, latch)
         `CHK(result_bus.oe, (strobe === 2'b00) ? 12'hfff : 12'h000)
         `CHK(inverted_clock_out, ~conv_clock_in)
      end
      busy_q = busy_b;
   end

   // Cycle counter that cuts a hang short.
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         test_done();
      end
   end

   // Main sequence: aligned, skipped-edge, restart attempt, then boundary and random patterns.
   initial begin
      int i;
      repeat (12) @(negedge sys_clk);
      rst_b <= 1'b1;
      step();
      `CHK(busy_b, 1'b1)
      conv(0, 600, 12'($random(seed)), 1'b0, d_al);
      conv(18, 3, 12'($random(seed)), 1'b0, d_sk);
      `CHK(d_sk - d_al, 22)
      conv(0, 3, 12'($random(seed)), 1'b1, d_re);
      `CHK(d_re, d_al)
      for (i = 0; i < 4; i++) begin
         conv(0, 3, (i == 0) ? 12'hfff : (i == 1) ? 12'h000 : 12'($random(seed)), 1'b0, d_re);
      end
      test_done();
   end
endmodule
`default_nettype wire
